// ---- radio_irq_pkg.sv ----
// Constants, register map and field layout of the radio event interrupt logic.
// Assumes one 10 MHz clock and 8-bit registers at 10-bit addresses.
package radio_irq_pkg;

   // ***************************************************
   // Bus widths
   // ***************************************************
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int EV_W = 16; // {source hi, source lo}

   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [9:0] OFS_IRQ_OUT1_ENABLE_LO = 10'h3c7;
   localparam logic [9:0] OFS_IRQ_OUT1_ENABLE_HI = 10'h3c8;
   localparam logic [9:0] OFS_IRQ_OUT2_ENABLE_LO = 10'h3c9;
   localparam logic [9:0] OFS_IRQ_OUT2_ENABLE_HI = 10'h3ca;
   localparam logic [9:0] OFS_EVENT_SOURCE_LO = 10'h3cb;
   localparam logic [9:0] OFS_EVENT_SOURCE_HI = 10'h3cc;
   localparam logic [9:0] OFS_SUPPLY_MONITOR_CONFIG = 10'h3e6;

   // ***************************************************
   // Field positions, low source group
   // ***************************************************
   localparam int BIT_POWERUP = 1;
   localparam int BIT_WAKEUP = 2;
   localparam int BIT_READY = 3;
   localparam int BIT_POR = 4;
   localparam int BIT_LOW_SUPPLY = 5;

   // ***************************************************
   // Field positions, high source group
   // ***************************************************
   localparam int BIT_CCA_DONE = 0;
   localparam int BIT_RX_DELIM = 1;
   localparam int BIT_TX_DELIM = 2;
   localparam int BIT_RX_FRAME = 3;
   localparam int BIT_TX_FRAME = 4;

   // ***************************************************
   // Implemented bits and reset values
   // ***************************************************
   localparam logic [7:0] LO_MASK = 8'h3e;
   localparam logic [7:0] HI_MASK = 8'h1f;
   localparam logic [7:0] CFG_MASK = 8'h1f;
   localparam logic [7:0] EN_LO_RST = 8'h02;
   localparam logic [7:0] EN_HI_RST = 8'h00;
   localparam logic [7:0] SRC_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] RDATA_NONE = 8'h00;

   // ***************************************************
   // Supply monitor trip level in millivolts
   // ***************************************************
   localparam int SUPPLY_W = 12;
   localparam int TRIP_W = 5;
   localparam logic [11:0] TRIP_BASE_MV = 12'h6a4; // 1700 mV
   localparam logic [11:0] TRIP_STEP_MV = 12'h03e; // 62 mV

   // ***************************************************
   // Register select
   // ***************************************************
   typedef enum logic [2:0] {
      SEL_NONE, SEL_EN1_LO, SEL_EN1_HI, SEL_EN2_LO, SEL_EN2_HI,
      SEL_SRC_LO, SEL_SRC_HI, SEL_CFG
   } reg_sel_t;

endpackage

// ---- event_if.sv ----
// Interface carrying raw events, edge pulses and supply figures between the core
// and its event capture and supply monitor modules; all on one clock.
`timescale 1ns/1ps
interface event_if;
   logic [15:0] raw;
   logic [15:0] pulse;
   logic [11:0] supply_mv;
   logic [4:0] trip_code;
   logic low_pulse;

   modport capture (input raw, output pulse);
   modport monitor (input supply_mv, trip_code, output low_pulse);
   modport core (output raw, supply_mv, trip_code, input pulse, low_pulse);
endinterface

// ---- event_capture.sv ----
// Rising-edge detector turning each raw event level into a one-cycle pulse.
// Assumes raw events are synchronous to mclk.
`timescale 1ns/1ps
module event_capture (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Event lines
   event_if.capture ev
);

   typedef struct packed {
      logic [15:0] prev;
      logic [15:0] pulse;
   } cap_t;

   cap_t st_reg;
   cap_t st_next;

   // One edge detector per event line
   for (genvar i = 0; i < radio_irq_pkg::EV_W; i++) begin : g_edge
      always_comb begin
         st_next.prev[i] = ev.raw[i];
         st_next.pulse[i] = ev.raw[i] & ~st_reg.prev[i];
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ev.pulse = st_reg.pulse;

endmodule // event_capture

// ---- supply_monitor.sv ----
// Battery supply comparator: flags the fall below the programmed trip level.
// Assumes the supply reading arrives in millivolts, synchronous to mclk.
`timescale 1ns/1ps
module supply_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Supply figures
   event_if.monitor ev
);

   typedef struct packed {
      logic low;
      logic low_pulse;
   } mon_t;

   mon_t st_reg;
   mon_t st_next;
   logic [11:0] trip_mv;
   logic [11:0] step_mv;

   // Trip level: base plus step times code
   always_comb begin
      step_mv = 12'(radio_irq_pkg::TRIP_STEP_MV * ev.trip_code);
      trip_mv = 12'(radio_irq_pkg::TRIP_BASE_MV + step_mv);
   end

   // Compare and detect the fall below the trip level
   always_comb begin
      st_next.low = ev.supply_mv < trip_mv;
      st_next.low_pulse = st_next.low & ~st_reg.low;
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ev.low_pulse = st_reg.low_pulse;

endmodule // supply_monitor

// ---- radio_event_interrupt_logic.sv ----
// Interrupt logic of a 2.4 GHz radio: event sources, two enable sets,
// two interrupt outputs and the battery monitor trip setting.
// Assumes a register port on mclk and event inputs synchronous to mclk.
`timescale 1ns/1ps
module radio_event_interrupt_logic (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,

   // Register port
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,

   // Radio events
   input wire logic cca_result_valid,
   input wire logic rx_frame_stored,
   input wire logic tx_frame_sent,
   input wire logic tx_delim_sent,
   input wire logic rx_delim_found,

   // System events
   input wire logic controller_accept_flag,
   input wire logic wakeup_expired,
   input wire logic chip_ready,
   input wire logic [11:0] battery_supply,

   // Interrupt outputs
   output logic irq_out1,
   output logic irq_out2
);

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [7:0] en1_lo;
      logic [7:0] en1_hi;
      logic [7:0] en2_lo;
      logic [7:0] en2_hi;
      logic [7:0] src_lo;
      logic [7:0] src_hi;
      logic [7:0] cfg;
      logic [7:0] rdata;
      logic irq1;
      logic irq2;
      logic por_seen;
   } core_t;

   core_t st_reg;
   core_t st_next;

   // ***************************************************
   // Decoding functions
   // ***************************************************

   // Address to register select
   function automatic radio_irq_pkg::reg_sel_t decode(input logic [9:0] a);
      radio_irq_pkg::reg_sel_t s;
      s = radio_irq_pkg::SEL_NONE;
      unique case (a)
         radio_irq_pkg::OFS_IRQ_OUT1_ENABLE_LO: s = radio_irq_pkg::SEL_EN1_LO;
         radio_irq_pkg::OFS_IRQ_OUT1_ENABLE_HI: s = radio_irq_pkg::SEL_EN1_HI;
         radio_irq_pkg::OFS_IRQ_OUT2_ENABLE_LO: s = radio_irq_pkg::SEL_EN2_LO;
         radio_irq_pkg::OFS_IRQ_OUT2_ENABLE_HI: s = radio_irq_pkg::SEL_EN2_HI;
         radio_irq_pkg::OFS_EVENT_SOURCE_LO: s = radio_irq_pkg::SEL_SRC_LO;
         radio_irq_pkg::OFS_EVENT_SOURCE_HI: s = radio_irq_pkg::SEL_SRC_HI;
         radio_irq_pkg::OFS_SUPPLY_MONITOR_CONFIG: s = radio_irq_pkg::SEL_CFG;
         default: s = radio_irq_pkg::SEL_NONE;
      endcase
      return s;
   endfunction

   // Implemented bits of each register
   function automatic logic [7:0] bit_mask(input radio_irq_pkg::reg_sel_t s);
      logic [7:0] m;
      m = 8'h00;
      unique case (s)
         radio_irq_pkg::SEL_EN1_LO,
         radio_irq_pkg::SEL_EN2_LO,
         radio_irq_pkg::SEL_SRC_LO: m = radio_irq_pkg::LO_MASK;
         radio_irq_pkg::SEL_EN1_HI,
         radio_irq_pkg::SEL_EN2_HI,
         radio_irq_pkg::SEL_SRC_HI: m = radio_irq_pkg::HI_MASK;
         radio_irq_pkg::SEL_CFG: m = radio_irq_pkg::CFG_MASK;
         radio_irq_pkg::SEL_NONE: m = 8'h00;
      endcase
      return m;
   endfunction

   // Stored value of a register, reserved bits not yet masked
   function automatic logic [7:0] read_value(
      input radio_irq_pkg::reg_sel_t s,
      input core_t c
   );
      logic [7:0] v;
      v = radio_irq_pkg::RDATA_NONE;
      unique case (s)
         radio_irq_pkg::SEL_EN1_LO: v = c.en1_lo;
         radio_irq_pkg::SEL_EN1_HI: v = c.en1_hi;
         radio_irq_pkg::SEL_EN2_LO: v = c.en2_lo;
         radio_irq_pkg::SEL_EN2_HI: v = c.en2_hi;
         radio_irq_pkg::SEL_SRC_LO: v = c.src_lo;
         radio_irq_pkg::SEL_SRC_HI: v = c.src_hi;
         radio_irq_pkg::SEL_CFG: v = c.cfg;
         radio_irq_pkg::SEL_NONE: v = radio_irq_pkg::RDATA_NONE;
      endcase
      return v;
   endfunction

   // Write-one-clear term of one source group
   function automatic logic [7:0] clear_term(
      input radio_irq_pkg::reg_sel_t s,
      input radio_irq_pkg::reg_sel_t group,
      input logic [7:0] v
   );
      logic [7:0] c;
      c = (s == group) ? v : 8'h00;
      return c;
   endfunction

   // Sticky update of one source group; a set beats a clear in the same cycle
   function automatic logic [7:0] sticky(
      input logic [7:0] old_v,
      input logic [7:0] clr_v,
      input logic [7:0] set_v
   );
      logic [7:0] v;
      v = (old_v & ~clr_v) | set_v;
      return v;
   endfunction

   // Any set source bit whose enable bit is set too
   function automatic logic any_enabled(
      input logic [7:0] src_hi,
      input logic [7:0] src_lo,
      input logic [7:0] en_hi,
      input logic [7:0] en_lo
   );
      logic hit;
      hit = |({src_hi, src_lo} & {en_hi, en_lo});
      return hit;
   endfunction

   // ***************************************************
   // Event capture and supply monitor
   // ***************************************************
   event_if ev ();

   event_capture u_capture (
      .mclk(mclk),
      .rst_n(rst_n),
      .ev(ev.capture)
   );

   supply_monitor u_monitor (
      .mclk(mclk),
      .rst_n(rst_n),
      .ev(ev.monitor)
   );

   // Raw event lines in source register layout
   // Unused lines stay low, so no false edge follows reset
   always_comb begin
      ev.raw = 16'h0000;
      ev.raw[8 + radio_irq_pkg::BIT_CCA_DONE] = cca_result_valid;
      ev.raw[8 + radio_irq_pkg::BIT_RX_DELIM] = rx_delim_found;
      ev.raw[8 + radio_irq_pkg::BIT_TX_DELIM] = tx_delim_sent;
      ev.raw[8 + radio_irq_pkg::BIT_RX_FRAME] = rx_frame_stored;
      ev.raw[8 + radio_irq_pkg::BIT_TX_FRAME] = tx_frame_sent;
      ev.raw[radio_irq_pkg::BIT_POWERUP] = chip_ready;
      ev.raw[radio_irq_pkg::BIT_WAKEUP] = wakeup_expired;
      ev.raw[radio_irq_pkg::BIT_READY] = controller_accept_flag;
   end

   // Supply figures to the monitor
   assign ev.supply_mv = battery_supply;
   assign ev.trip_code = st_reg.cfg[4:0];

   // ***************************************************
   // Access decode
   // ***************************************************
   radio_irq_pkg::reg_sel_t wr_sel;
   radio_irq_pkg::reg_sel_t rd_sel;
   logic [7:0] wr_val;
   logic [7:0] set_lo;
   logic [7:0] set_hi;
   logic [7:0] clr_lo;
   logic [7:0] clr_hi;

   // Write select and masked write value
   always_comb begin
      wr_sel = reg_wr ? decode(reg_addr) : radio_irq_pkg::SEL_NONE;
      rd_sel = decode(reg_addr);
      wr_val = reg_wdata & bit_mask(wr_sel);
   end

   // Hardware set terms per source group
   always_comb begin
      set_lo = ev.pulse[7:0];
      set_lo[radio_irq_pkg::BIT_LOW_SUPPLY] = ev.low_pulse;
      set_lo[radio_irq_pkg::BIT_POR] = ~st_reg.por_seen;
      set_lo = set_lo & radio_irq_pkg::LO_MASK;
      set_hi = ev.pulse[15:8] & radio_irq_pkg::HI_MASK;
   end

   // Software clear terms: a one written clears the bit
   always_comb begin
      clr_lo = clear_term(wr_sel, radio_irq_pkg::SEL_SRC_LO, wr_val);
      clr_hi = clear_term(wr_sel, radio_irq_pkg::SEL_SRC_HI, wr_val);
   end

   // ***************************************************
   // Interrupt terms
   // ***************************************************
   logic irq1_hit;
   logic irq2_hit;

   // One request term per output from the present sources and enables
   always_comb begin
      irq1_hit = any_enabled(st_reg.src_hi, st_reg.src_lo, st_reg.en1_hi, st_reg.en1_lo);
      irq2_hit = any_enabled(st_reg.src_hi, st_reg.src_lo, st_reg.en2_hi, st_reg.en2_lo);
   end

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      st_next = st_reg;

      // Enable and configuration writes
      unique case (wr_sel)
         radio_irq_pkg::SEL_EN1_LO: st_next.en1_lo = wr_val;
         radio_irq_pkg::SEL_EN1_HI: st_next.en1_hi = wr_val;
         radio_irq_pkg::SEL_EN2_LO: st_next.en2_lo = wr_val;
         radio_irq_pkg::SEL_EN2_HI: st_next.en2_hi = wr_val;
         radio_irq_pkg::SEL_CFG: st_next.cfg = wr_val;
         default: st_next.cfg = st_reg.cfg;
      endcase

      // Sticky sources; an event beside a clear is never lost
      st_next.src_lo = sticky(st_reg.src_lo, clr_lo, set_lo);
      st_next.src_hi = sticky(st_reg.src_hi, clr_hi, set_hi);

      // Power-on event raised once after reset
      // Flag stays set until the next reset, so the event never repeats
      st_next.por_seen = 1'b1;

      // Read data, valid in the cycle after the strobe
      // Zero outside the answer cycle keeps stale data off the port
      st_next.rdata = radio_irq_pkg::RDATA_NONE;
      if (reg_rd) begin
         st_next.rdata = read_value(rd_sel, st_reg) & bit_mask(rd_sel);
      end

      // Interrupt outputs, registered so they lag the sources by one cycle
      st_next.irq1 = irq1_hit;
      st_next.irq2 = irq2_hit;
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.en1_lo <= radio_irq_pkg::EN_LO_RST;
         st_reg.en1_hi <= radio_irq_pkg::EN_HI_RST;
         st_reg.en2_lo <= radio_irq_pkg::EN_LO_RST;
         st_reg.en2_hi <= radio_irq_pkg::EN_HI_RST;
         st_reg.src_lo <= radio_irq_pkg::SRC_RST;
         st_reg.src_hi <= radio_irq_pkg::SRC_RST;
         st_reg.cfg <= radio_irq_pkg::CFG_RST;
         st_reg.rdata <= radio_irq_pkg::RDATA_NONE;
         st_reg.irq1 <= 1'b0;
         st_reg.irq2 <= 1'b0;
         st_reg.por_seen <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign reg_rdata = st_reg.rdata;
   assign irq_out1 = st_reg.irq1;
   assign irq_out2 = st_reg.irq2;

endmodule // radio_event_interrupt_logic

// ---- radio_irq_chk.sv ----
// Port checker for the radio event interrupt logic.
// Assumes one mclk domain and binding to the top module.
`timescale 1ns/1ps
module radio_irq_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Events
   input wire logic cca_result_valid,
   input wire logic rx_frame_stored,
   input wire logic controller_accept_flag,
   input wire logic chip_ready,
   input wire logic [11:0] battery_supply,
   // Interrupts
   input wire logic irq_out1,
   input wire logic irq_out2
);
   // ****
   // Shadow settings
   // ****
   logic [7:0] e1l_reg;
   logic [7:0] e2h_reg;
   logic [4:0] cfg_reg;
   logic low;
   // Mirror of enable and trip writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         e1l_reg <= 8'h02;
         e2h_reg <= 8'h00;
         cfg_reg <= 5'h00;
      end else if (reg_wr) begin
         if (reg_addr == 10'h3c7) e1l_reg <= reg_wdata;
         if (reg_addr == 10'h3ca) e2h_reg <= reg_wdata;
         if (reg_addr == 10'h3e6) cfg_reg <= reg_wdata[4:0];
      end
   end
   // Supply below trip level
   assign low = battery_supply < (12'h6a4 + 12'h03e * {7'h00, cfg_reg});

   // ****
   // Properties
   // ****
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("data outside answer");
   property p_rd_lo;
      $past(reg_rd) && $past(reg_addr) inside {10'h3c7, 10'h3c9, 10'h3cb}
         |-> (reg_rdata & 8'hc1) == 8'h00;
   endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("reserved low bits set");
   property p_rd_hi;
      $past(reg_rd) && $past(reg_addr) inside {10'h3c8, 10'h3ca, 10'h3cc, 10'h3e6}
         |-> reg_rdata[7:5] == 3'h0;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("reserved high bits set");
   property p_powerup;
      $rose(chip_ready) && e1l_reg[1] |-> ##[1:5] irq_out1;
   endproperty
   a_powerup: assert property (p_powerup) else $error("chip ready lost");
   property p_cca;
      $rose(cca_result_valid) && e2h_reg[0] |-> ##[1:5] irq_out2;
   endproperty
   a_cca: assert property (p_cca) else $error("cca done lost");
   property p_rx;
      $rose(rx_frame_stored) && e2h_reg[3] |-> ##[1:5] irq_out2;
   endproperty
   a_rx: assert property (p_rx) else $error("frame received lost");
   property p_ready;
      $rose(controller_accept_flag) && e1l_reg[3] |-> ##[1:5] irq_out1;
   endproperty
   a_ready: assert property (p_ready) else $error("controller ready lost");
   property p_supply;
      $rose(low) && e1l_reg[5] |-> ##[1:5] irq_out1;
   endproperty
   a_supply: assert property (p_supply) else $error("low supply lost");
   // Main scenarios reached
   c_irq1: cover property ($rose(irq_out1));
   c_irq2: cover property ($rose(irq_out2));
   c_low: cover property ($rose(low));
endmodule // radio_irq_chk

bind radio_event_interrupt_logic radio_irq_chk i_radio_irq_chk (.*);

// ---- irq_host_model.sv ----
// Host model: watches both interrupt pins and counts their rising edges.
// Assumes level pins registered on mclk.
`timescale 1ns/1ps
module irq_host_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Interrupt pins
   input wire logic irq_out1,
   input wire logic irq_out2,
   // Requests seen
   output logic [7:0] rise1,
   output logic [7:0] rise2
);
   logic p1_reg;
   logic p2_reg;
   // Edge counting of both pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         p1_reg <= 1'b0;
         p2_reg <= 1'b0;
         rise1 <= 8'h00;
         rise2 <= 8'h00;
      end else begin
         p1_reg <= irq_out1;
         p2_reg <= irq_out2;
         rise1 <= rise1 + {7'h00, irq_out1 & ~p1_reg};
         rise2 <= rise2 + {7'h00, irq_out2 & ~p2_reg};
      end
   end
endmodule // irq_host_model

// ---- radio_event_interrupt_logic_tb.sv ----
// Testbench for the radio event interrupt logic.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module radio_event_interrupt_logic_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [11:0] battery_supply = 12'hbb8;
   logic [7:0] reg_rdata;
   logic irq_out1;
   logic irq_out2;
   logic [7:0] rise1;
   logic [7:0] rise2;
   int errors = 0;
   int comparisons = 0;
   // Register map, reset values, event source patterns {hi, lo}
   logic [9:0] ra [8] = '{10'h3c7, 10'h3c8, 10'h3c9, 10'h3ca, 10'h3cb, 10'h3cc, 10'h3e6, 10'h3cd};
   logic [7:0] rv [8] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
   logic [15:0] ex [8] = '{16'h0100, 16'h0800, 16'h1000, 16'h0400, 16'h0200,
      16'h0008, 16'h0004, 16'h0002};

   // 10 MHz clock
   always #50 mclk = ~mclk;

   radio_event_interrupt_logic i_radio_event_interrupt_logic (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cca_result_valid(ev[0]), .rx_frame_stored(ev[1]), .tx_frame_sent(ev[2]),
      .tx_delim_sent(ev[3]), .rx_delim_found(ev[4]), .controller_accept_flag(ev[5]),
      .wakeup_expired(ev[6]), .chip_ready(ev[7]), .battery_supply(battery_supply),
      .irq_out1(irq_out1), .irq_out2(irq_out2));

   irq_host_model i_irq_host_model (.mclk(mclk), .rst_n(rst_n), .irq_out1(irq_out1),
      .irq_out2(irq_out2), .rise1(rise1), .rise2(rise2));

   // Verdict and end of run
   task automatic close_out();
      $display("Comparisons %0d, errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle register write
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read, data checked in the answer cycle
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask

   // One-cycle event pulse, then bounded wait for the second output
   task automatic fire(input int i);
      int n = 0;
      @(posedge mclk);
      ev <= 8'h01 << i;
      @(posedge mclk);
      ev <= 8'h00;
      #1;
      while (irq_out2 !== 1'b1 && n < 10) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n == 10) begin
         errors++;
         close_out();
      end
   endtask

   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (ra[i]) begin
         rd(ra[i], rv[i]);
      end
      wr(10'h3cb, 8'hff);
      rd(10'h3cb, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(ra[i], 8'hff);
         rd(ra[i], i[0] ? 8'h1f : 8'h3e);
      end
      // Every event line, both outputs enabled
      for (int i = 0; i < 8; i++) begin
         fire(i);
         rd(10'h3cb, ex[i][7:0]);
         rd(10'h3cc, ex[i][15:8]);
         check({6'h00, irq_out1, irq_out2}, 8'h03);
         wr(10'h3cb, 8'hff);
         wr(10'h3cc, 8'hff);
         repeat (3) @(posedge mclk);
         #1;
         check({6'h00, irq_out1, irq_out2}, 8'h00);
      end
      check(rise1, 8'h08);
      check(rise2, 8'h08);
      // Output one masked off
      wr(10'h3c7, 8'h00);
      wr(10'h3c8, 8'h00);
      fire(0);
      repeat (2) @(posedge mclk);
      #1;
      check({7'h00, irq_out1}, 8'h00);
      wr(10'h3cc, 8'hff);
      wr(10'h3c7, 8'hff);
      // Trip code 5: 1700 + 62 * 5 = 2010 mV, reserved bits dropped
      wr(10'h3e6, 8'he5);
      rd(10'h3e6, 8'h05);
      @(posedge mclk);
      battery_supply <= 12'h7da;
      repeat (6) @(posedge mclk);
      rd(10'h3cb, 8'h00);
      @(posedge mclk);
      battery_supply <= 12'h7d9;
      fire(8);
      rd(10'h3cb, 8'h20);
      check({7'h00, irq_out1}, 8'h01);
      close_out();
   end
endmodule // radio_event_interrupt_logic_tb
